// ==== pdm_load_model.sv ====
`timescale 1ns/1ps
module pdm_load_model (
    // clock and window control
    input wire clock_i,
    input wire clear_i,
    input wire [2:0] pin_sel_i,
    // port 2 pins
    input wire [7:0] pin_i,
    input wire [7:0] oe_i,
    output logic [7:0] level_o = 8'h00,
    // high cycles and rising edges seen on the chosen pin
    output logic [15:0] highs_o,
    output logic [15:0] rises_o
);
    wire lvl = pin_i[pin_sel_i] & oe_i[pin_sel_i];
    logic was_r;
    // released pins flip each cycle so no stale level is taken as valid
    always @(posedge clock_i) begin
        level_o <= (pin_i & oe_i) | (~level_o & ~oe_i);
        was_r <= lvl;
        highs_o <= clear_i ? 16'h0 : highs_o + {15'h0, lvl};
        rises_o <= clear_i ? 16'h0 : rises_o + {15'h0, lvl & !was_r};
    end
endmodule

// ==== pdm_modulator.v ====
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "pdm_regs.vh"

// What this block does
// [RULE_01] enable bit 4 runs modulator; off leaves pin general purpose
// [RULE_02] clock select divides master clock by two to the field value
// [RULE_03] density word high and low bytes, read/write, reset to zero
// [RULE_04] data bit 15 selects the fastest stage at half tick rate
// [RULE_05] each lower bit selects a stage at half the rate above it
// [RULE_06] software sets clock, enable, divider, then density word
// [RULE_07] software then sets port 2 bit 2 direction and pin route
// [RULE_08] route bit in port 2 mode register puts modulator on bit 2
// [RULE_09] control bits 7,6,5,3 read zero; enable and select reset zero
// [RULE_10] duty equals word over 65536; never constantly high
// [RULE_11] second route bit 6 puts modulator on port 2 bit 5
// [RULE_12] stages from free 16-bit counter, non-overlapping, ORed
module pdm_modulator (
    // clock and reset
    input wire clock_i,
    input wire resetn_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [9:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // port 2 pins
    input wire [7:0] port2_pin_i,
    output wire [7:0] port2_pin_o,
    output wire [7:0] port2_pin_oe_o,
    // modulator state
    output wire modulator_out_o
);
    reg [7:0] port2_latch_r;
    reg [7:0] port2_direction_r;
    reg [7:0] port2_mode_select_r;
    reg [15:0] density_word_a_r;
    reg [15:0] density_word_b_r;
    reg [7:0] modulator_control_r;
    reg [15:0] stage_count_r;
    reg stage_out_r;
    reg [7:0] pin_sync1_r;
    reg [7:0] pin_sync2_r;
    reg [7:0] rd_byte;
    reg hit;
    reg [15:0] stage_sel;
    reg [7:0] pin_out_r;
    wire [7:0] idx;
    wire wr_en;
    wire modulator_on;
    wire modulator_tick;
    wire [15:0] count_nxt;
    integer i;

    // word-aligned index decode
    assign idx = paddr_i[9:2];
    assign wr_en = psel_i && penable_i && pwrite_i && hit;
    assign modulator_on = modulator_control_r[`PDM_CTL_ON_BIT];

    // tick generator
    pdm_tick_divider u_div (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .run_i(modulator_on),
        .select_i(modulator_control_r[`PDM_CTL_SEL_MSB:`PDM_CTL_SEL_LSB]),
        .tick_o(modulator_tick)
    );

    // address decode and read mux
    always @* begin
        hit = 1'b1;
        rd_byte = 8'h00;
        case (idx)
            `PDM_IDX_PORT2_LATCH: rd_byte = pin_sync2_r;
            `PDM_IDX_PORT2_DIR: rd_byte = port2_direction_r;
            `PDM_IDX_PORT2_MODE: rd_byte = port2_mode_select_r;
            `PDM_IDX_DENS_HIGH: rd_byte = density_word_a_r[15:8]; // [RULE_03]
            `PDM_IDX_DENS_LOW: rd_byte = density_word_a_r[7:0]; // [RULE_03]
            `PDM_IDX_DENS_B_HIGH: rd_byte = density_word_b_r[15:8];
            `PDM_IDX_DENS_B_LOW: rd_byte = density_word_b_r[7:0];
            `PDM_IDX_CONTROL: rd_byte = modulator_control_r; // [RULE_09]
            default: hit = 1'b0;
        endcase
    end

    // zero-wait slave; unmapped access answers with an error
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign prdata_o = {24'h000000, rd_byte};

    // register writes
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            port2_latch_r <= `PDM_RST_BYTE;
            port2_direction_r <= `PDM_RST_BYTE;
            port2_mode_select_r <= `PDM_RST_BYTE;
            density_word_a_r <= `PDM_RST_WORD;
            density_word_b_r <= `PDM_RST_WORD;
            modulator_control_r <= `PDM_RST_BYTE;
        end else if (wr_en) begin
            case (idx)
                `PDM_IDX_PORT2_LATCH: port2_latch_r <= pwdata_i[7:0];
                `PDM_IDX_PORT2_DIR: port2_direction_r <= pwdata_i[7:0];
                `PDM_IDX_PORT2_MODE:
                    port2_mode_select_r <= pwdata_i[7:0] & `PDM_MODE_MASK;
                `PDM_IDX_DENS_HIGH:
                    density_word_a_r[15:8] <= pwdata_i[7:0]; // [RULE_03]
                `PDM_IDX_DENS_LOW:
                    density_word_a_r[7:0] <= pwdata_i[7:0]; // [RULE_03]
                `PDM_IDX_DENS_B_HIGH: density_word_b_r[15:8] <= pwdata_i[7:0];
                `PDM_IDX_DENS_B_LOW: density_word_b_r[7:0] <= pwdata_i[7:0];
                `PDM_IDX_CONTROL:
                    modulator_control_r <= pwdata_i[7:0] & `PDM_CTL_MASK; // [RULE_09]
                default: port2_latch_r <= port2_latch_r;
            endcase
        end
    end

    // pin input synchroniser
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            pin_sync1_r <= 8'h00;
            pin_sync2_r <= 8'h00;
        end else begin
            pin_sync1_r <= port2_pin_i;
            pin_sync2_r <= pin_sync1_r;
        end
    end

    // free-running stage counter advanced by the tick
    assign count_nxt = stage_count_r + 16'h0001;
    always @(posedge clock_i) begin
        if (!resetn_i || !modulator_on) begin
            stage_count_r <= 16'h0000; // [RULE_01]
        end else if (modulator_tick) begin
            stage_count_r <= count_nxt; // [RULE_12]
        end
    end

    // stage k is high once per 2**(16-k) ticks: bit 15 every 2nd tick,
    // bit 0 once per 65536; lowest set bit picks the one live stage,
    // so pulses never overlap and duty is word/65536
    always @* begin
        stage_sel = 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            if (stage_count_r[15 - i] &&
                    (stage_count_r & ((16'h0001 << (15 - i)) - 16'h0001))
                    == 16'h0000) begin
                stage_sel[i] = 1'b1; // [RULE_04] [RULE_05]
            end
        end
    end

    // or of the selected stages, registered
    always @(posedge clock_i) begin
        if (!resetn_i || !modulator_on) begin
            stage_out_r <= 1'b0;
        end else begin
            stage_out_r <= |(stage_sel & density_word_a_r); // [RULE_12] [RULE_10]
        end
    end

    // pin multiplexer: route bit replaces the latch when modulator runs
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            pin_out_r <= 8'h00;
        end else begin
            pin_out_r <= port2_latch_r;
            if (modulator_on &&
                    port2_mode_select_r[`PDM_MODE_ROUTE_BIT]) begin
                pin_out_r[`PDM_PIN_FIRST] <= stage_out_r; // [RULE_08] [RULE_01]
            end
            if (modulator_on &&
                    port2_mode_select_r[`PDM_MODE_ROUTE2_BIT]) begin
                pin_out_r[`PDM_PIN_SECOND] <= stage_out_r; // [RULE_11]
            end
        end
    end

    // direction register drives the enables; software sets it per pin
    assign port2_pin_oe_o = port2_direction_r; // [RULE_07]
    assign port2_pin_o = pin_out_r;
    assign modulator_out_o = stage_out_r;
endmodule

// ==== pdm_modulator_asserts.sv ====
`timescale 1ns/1ps
module pdm_modulator_asserts (
    // watched ports
    input wire clock_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [9:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire [7:0] port2_pin_o,
    input wire modulator_out_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    wire wr = psel_i & penable_i & pwrite_i;
    wire rd = psel_i & penable_i & !pwrite_i;
    wire [7:0] ix = paddr_i[9:2];
    logic [7:0] ctl_r, mode_r, hi_r, lo_r;
    logic [2:0] run_r;
    wire top = (ctl_r & 8'h17) == 8'h10 && {hi_r, lo_r} == 16'h8000;
    // shadow registers, updated at the edge a write is taken
    always @(posedge clock_i) begin
        if (!resetn_i) begin
            {ctl_r, mode_r, hi_r, lo_r} <= 32'h0;
        end else if (wr) begin
            if (ix == 8'h36) ctl_r <= pwdata_i[7:0];
            if (ix == 8'h27) mode_r <= pwdata_i[7:0];
            if (ix == 8'h30) hi_r <= pwdata_i[7:0];
            if (ix == 8'h31) lo_r <= pwdata_i[7:0];
        end
    end
    // cycles the fastest-stage setup has stood, saturating at 7
    always @(posedge clock_i) begin
        run_r <= !top ? 3'h0 : (run_r == 3'h7 ? run_r : run_r + 3'h1);
    end
    a_ctl_unused: assert property (rd && ix == 8'h36 |->
        (prdata_o & 32'hffffffe8) == 0) else $error("control spare bits");
    a_mode_unused: assert property (rd && ix == 8'h27 |->
        (prdata_o & 32'hffffffaf) == 0) else $error("mode spare bits");
    a_density_read: assert property (rd && ix[7:1] == 7'h18 |->
        prdata_o == {24'h0, ix[0] ? lo_r : hi_r}) else $error("density");
    a_off_quiet: assert property (wr && ix == 8'h36 && !pwdata_i[4]
        |-> ##3 !modulator_out_o) else $error("output while off");
    a_zero_word: assert property ({hi_r, lo_r} == 0
        && $past({hi_r, lo_r}) == 0 |=> !modulator_out_o)
        else $error("output with zero word");
    a_route_first: assert property ($past(ctl_r[4] && mode_r[4])
        |-> port2_pin_o[2] == $past(modulator_out_o)) else $error("pin 2");
    a_route_second: assert property ($past(ctl_r[4] && mode_r[6])
        |-> port2_pin_o[5] == $past(modulator_out_o)) else $error("pin 5");
    a_top_toggle: assert property (run_r == 3'h7
        |-> modulator_out_o != $past(modulator_out_o)) else $error("toggle");
endmodule
bind pdm_modulator pdm_modulator_asserts pdm_modulator_asserts_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .port2_pin_o(port2_pin_o),
    .modulator_out_o(modulator_out_o));

// ==== pdm_regs.vh ====
`ifndef PDM_REGS_VH
`define PDM_REGS_VH

// register byte offsets (printed offsets are not all multiples of four,
// so each printed offset is an index and the byte address is index * 4)
`define PDM_IDX_PORT2_MODE 8'h27
`define PDM_IDX_DENS_HIGH 8'h30
`define PDM_IDX_DENS_LOW 8'h31
`define PDM_IDX_DENS_B_HIGH 8'h32
`define PDM_IDX_DENS_B_LOW 8'h33
`define PDM_IDX_CONTROL 8'h36
`define PDM_IDX_PORT2_LATCH 8'h24
`define PDM_IDX_PORT2_DIR 8'h25

// control register fields
`define PDM_CTL_ON_BIT 4
`define PDM_CTL_SEL_MSB 2
`define PDM_CTL_SEL_LSB 0
`define PDM_CTL_MASK 8'h17

// port 2 mode register fields
`define PDM_MODE_ROUTE_BIT 4
`define PDM_MODE_ROUTE2_BIT 6
`define PDM_MODE_MASK 8'h50

// reset values
`define PDM_RST_BYTE 8'h00
`define PDM_RST_WORD 16'h0000

// pin positions within port 2
`define PDM_PIN_FIRST 2
`define PDM_PIN_SECOND 5

// divider width: up to divide by 128
`define PDM_DIV_W 7

`endif

// ==== pdm_tick_divider.v ====
`timescale 1ns/1ps
// makes a one-cycle tick at clock / 2**select; select 0 ticks every cycle
module pdm_tick_divider (
    // clock and reset
    input wire clock_i,
    input wire resetn_i,
    // control
    input wire run_i,
    input wire [2:0] select_i,
    // tick out
    output wire tick_o
);
    reg [6:0] count_r;
    reg [6:0] limit;

    // terminal count is 2**select - 1
    always @* begin
        case (select_i)
            3'h0: limit = 7'h00;
            3'h1: limit = 7'h01;
            3'h2: limit = 7'h03;
            3'h3: limit = 7'h07;
            3'h4: limit = 7'h0f;
            3'h5: limit = 7'h1f;
            3'h6: limit = 7'h3f;
            default: limit = 7'h7f;
        endcase
    end

    // free counter, held at zero while stopped
    always @(posedge clock_i) begin
        if (!resetn_i || !run_i) begin
            count_r <= 7'h00;
        end else if (count_r >= limit) begin
            count_r <= 7'h00;
        end else begin
            count_r <= count_r + 7'h01;
        end
    end

    assign tick_o = run_i && (count_r >= limit); // [RULE_02]
endmodule

// ==== pulse_density_modulator_tb.sv ====
`timescale 1ns/1ps
module pulse_density_modulator_tb;
    typedef struct {logic [7:0] ix, d, e; logic w;} pdm_row_t;
    logic clock_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0;
    logic pwrite_i = 0, clr = 0, err = 0;
    logic [2:0] pin = 3'h2;
    logic [9:0] paddr_i = 10'h000;
    logic [31:0] pwdata_i = 32'h0, rd;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, mod_o;
    wire [7:0] p_o, p_oe, p_in;
    wire [15:0] highs, rises;
    int mismatches = 0, num_checks = 0, cycles = 0;
    pdm_row_t rows [10] = '{'{8'h30, 0, 0, 0}, '{8'h31, 0, 0, 0},
        '{8'h36, 0, 0, 0}, '{8'h27, 0, 0, 0}, '{8'h36, 8'hff, 8'h17, 1},
        '{8'h27, 8'hff, 8'h50, 1}, '{8'h30, 8'ha5, 8'ha5, 1},
        '{8'h31, 8'h5a, 8'h5a, 1}, '{8'h3f, 8'h11, 0, 1},
        '{8'h25, 8'hff, 8'hff, 1}};
    always #12.5 clock_i = ~clock_i;
    pdm_modulator pdm_modulator_i (.clock_i(clock_i), .resetn_i(resetn_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .port2_pin_i(p_in),
        .port2_pin_o(p_o), .port2_pin_oe_o(p_oe), .modulator_out_o(mod_o));
    pdm_load_model pdm_load_model_i (.clock_i(clock_i), .clear_i(clr),
        .pin_sel_i(pin), .pin_i(p_o), .oe_i(p_oe), .level_o(p_in),
        .highs_o(highs), .rises_o(rises));
    task automatic chk(input string n, input [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input [7:0] ix, input w, input [7:0] d);
        @(posedge clock_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= {ix, 2'b00};
        pwdata_i <= {24'h0, d};
        @(posedge clock_i);
        penable_i <= 1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    // let the output settle, then count over a 512 cycle window
    task automatic meas(input [2:0] p, input [15:0] eh, er);
        pin <= p;
        repeat (300) @(posedge clock_i);
        clr <= 1;
        @(posedge clock_i);
        clr <= 0;
        repeat (512) @(posedge clock_i);
        #1;
        chk("highs", {16'h0, highs}, {16'h0, eh});
        chk("rises", {16'h0, rises}, {16'h0, er});
        $display("test pin %0d done", p);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge clock_i);
        resetn_i <= 1;
        foreach (rows[i]) begin
            if (rows[i].w) apb(rows[i].ix, 1, rows[i].d);
            apb(rows[i].ix, 0, 8'h00);
            chk("reg", rd, {24'h0, rows[i].e});
        end
        $display("test registers done");
        apb(8'h36, 1, 8'h10);
        apb(8'h31, 1, 8'h00);
        apb(8'h30, 1, 8'h80);
        apb(8'h25, 1, 8'h24);
        apb(8'h27, 1, 8'h50);
        chk("oe", {24'h0, p_oe}, 32'h24);
        for (int s = 0; s < 8; s++) begin
            apb(8'h36, 1, 8'h10 | s[7:0]);
            meas(3'h2, 16'd256, 16'd256 >> s);
        end
        meas(3'h5, 16'd256, 16'd2);
        apb(8'h36, 1, 8'h10);
        apb(8'h30, 1, 8'hc0);
        meas(3'h2, 16'd384, 16'd128);
        apb(8'h30, 1, 8'h00);
        meas(3'h2, 16'd0, 16'd0);
        apb(8'h36, 1, 8'h00);
        apb(8'h24, 1, 8'h04);
        meas(3'h2, 16'd512, 16'd0);
        // mid-run reset clears registers and pins
        @(posedge clock_i);
        resetn_i <= 0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1;
        #1;
        chk("pins", {24'h0, p_o}, 32'h0);
        apb(8'h36, 0, 8'h00);
        chk("ctl", rd, 32'h0);
        apb(8'h30, 0, 8'h00);
        chk("dens", rd, 32'h0);
        apb(8'h3f, 0, 8'h00);
        chk("slverr", {31'h0, err}, 32'h1);
        $display("test reset done");
        finish_test();
    end
endmodule
